// file: hw/timer5_reload_capture_compare.sv
`timescale 1ns/1ps

// Contract
// - Reload mode, no trigger: FFFF wraps, sets overflow flag, loads reload value.
// - With trigger, overflow or pin edge reloads and sets event flag; both interrupt.
// - Run bit starts from the present count without clearing it.
// - Baud mode reloads on overflow but never raises the overflow flag.
// - Baud mode pin edge sets event flag without any reload.
// - Baud rate is prescaled clock over 16 times (65536 minus reload).
// - Capture modes: overflow sets flag, counting continues from zero, no reload.
// - Rising capture: edge copies count to reload-capture, sets event flag.
// - Falling capture: edge copies count to reload-capture, sets event flag.
// - Hardware sets overflow flag; only software clears it.
// - Hardware sets event flag on enabled external event; software clears it.
// - Prescaler divides by 1, 8, 64 or 256.
// - Mode field: reload, baud generator, rising capture, falling capture.
// - Capture source: event pin, low-frequency RC, serial one or two receive.
// - PWM polarity bit selects active level and acts at once.
// - Reload source: overflow, rise, fall, either edge, capture 0 or 1.
// - Extended mode: as mode field, both-edge capture, compare, PWM.
// - Compare mode: count equal to reload-capture sets overflow flag.
// - Compare-clear bit clears the count on a match.
// - PWM takes period from the period register and duty from the duty register.
// - Capture-clear bit zeroes the count after a capture.
module timer5_reload_capture_compare
    import timer5_pkg::*;
#(
    parameter int BAUD_OVERSAMPLE = 16
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // External inputs
    input  wire logic        event_pin,
    input  wire logic        lf_rc_clk_pin,
    input  wire logic        serial_one_receive_pin,
    input  wire logic        serial_two_receive_pin,
    // Outputs
    output logic             timer_irq,
    output logic             baud_tick,
    output logic             pwm_out
);

    if (BAUD_OVERSAMPLE < 2 || BAUD_OVERSAMPLE > 256 || (BAUD_OVERSAMPLE & (BAUD_OVERSAMPLE - 1)) != 0)
        $error("BAUD_OVERSAMPLE must be a power of two from 2 to 256");

    localparam int BW = $clog2(BAUD_OVERSAMPLE);

    // Bus state
    logic [7:0]  addr_q;
    logic        wr_q;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;

    // Registers
    logic [7:0]  control_q;
    logic [1:0]  source_q;
    logic [7:0]  extended_q;
    logic [15:0] count_q, count_d;
    logic [15:0] rcap_q, rcap_d;
    logic [15:0] period_q;
    logic [15:0] duty_q;
    logic        int_enable_q;
    logic        tf_q, exf_q;
    logic        tf_set, exf_set;

    // Engine state
    logic [7:0]    pre_q;
    logic [BW-1:0] baud_div_q;
    logic          baud_tick_q;
    logic          baud_ovf;
    logic          irq_q;
    logic          pwm_q;
    logic [3:0]    sync1_q, sync2_q, prev_q;

    // Address phase capture; writes land in the data phase
    wire        take    = hsel && htrans[1] && hready;
    wire [7:0]  raddr   = haddr[7:0];
    wire        wr_ctrl = wr_q && addr_q == CONTROL_OFFSET;
    wire        wr_src  = wr_q && addr_q == CAPTURE_SOURCE_OFFSET;
    wire        wr_ext  = wr_q && addr_q == EXTENDED_OFFSET;
    wire        wr_cnt  = wr_q && addr_q == COUNT_OFFSET;
    wire        wr_rcap = wr_q && addr_q == RELOAD_CAPTURE_OFFSET;
    wire        wr_per  = wr_q && addr_q == PERIOD_OFFSET;
    wire        wr_duty = wr_q && addr_q == DUTY_OFFSET;
    wire        wr_ie   = wr_q && addr_q == INT_ENABLE_OFFSET;

    // Control fields
    wire [7:0] control_view = {tf_q, exf_q, control_q[5:0]};
    wire [1:0] prescale_sel = control_q[PRESCALE_LSB +: 2];
    wire [1:0] mode_sel     = control_q[MODE_LSB +: 2];
    wire       run_bit      = control_q[RUN_BIT];
    wire       ext_en       = control_q[EXT_TRIGGER_BIT];
    wire       polarity     = extended_q[PWM_POLARITY_BIT];
    wire [2:0] reload_sel   = extended_q[RELOAD_SOURCE_LSB +: 3];
    wire [1:0] ext_mode     = extended_q[EXTENDED_MODE_LSB +: 2];
    wire       cmp_clear    = extended_q[COMPARE_CLEAR_BIT];
    wire       cap_clear    = extended_q[CAPTURE_CLEAR_BIT];

    // Read mux decided in the address phase so hrdata leaves a flop
    logic [31:0] rdata_mux;
    assign rdata_mux = (raddr == CONTROL_OFFSET)        ? {24'h000000, control_view} :
                       (raddr == CAPTURE_SOURCE_OFFSET) ? {30'h00000000, source_q} :
                       (raddr == EXTENDED_OFFSET)       ? {24'h000000, extended_q} :
                       (raddr == COUNT_OFFSET)          ? {16'h0000, count_q} :
                       (raddr == RELOAD_CAPTURE_OFFSET) ? {16'h0000, rcap_q} :
                       (raddr == PERIOD_OFFSET)         ? {16'h0000, period_q} :
                       (raddr == DUTY_OFFSET)           ? {16'h0000, duty_q} :
                       (raddr == INT_ENABLE_OFFSET)     ? {31'h00000000, int_enable_q} :
                                                          32'h00000000;

    // Prescaler terminal count
    wire [7:0] pre_end = (prescale_sel == 2'h0) ? PRESCALE_END_1 :
                         (prescale_sel == 2'h1) ? PRESCALE_END_8 :
                         (prescale_sel == 2'h2) ? PRESCALE_END_64 : PRESCALE_END_256;
    wire       tick    = run_bit && pre_q == pre_end;

    // Synchronised inputs: 0 event pin, 1 RC, 2 serial one, 3 serial two
    wire [3:0] rise = sync2_q & ~prev_q;
    wire [3:0] fall = ~sync2_q & prev_q;
    wire       cap_rise = rise[source_q];
    wire       cap_fall = fall[source_q];
    wire       pin_rise = rise[0];
    wire       pin_fall = fall[0];

    // Effective mode
    mode_type mode;
    assign mode = (ext_mode == 2'h1) ? MODE_CAPTURE_BOTH :
                  (ext_mode == 2'h2) ? MODE_COMPARE :
                  (ext_mode == 2'h3) ? MODE_PWM :
                  (mode_sel == 2'h0) ? MODE_AUTO_RELOAD :
                  (mode_sel == 2'h1) ? MODE_BAUD :
                  (mode_sel == 2'h2) ? MODE_CAPTURE_RISE : MODE_CAPTURE_FALL;

    // Reload trigger from pin or capture channels
    wire pin_edge_any = pin_rise || pin_fall;
    wire reload_evt   = (reload_sel == RELOAD_ON_OVERFLOW && ext_en && pin_edge_any) ||
                        (reload_sel == RELOAD_ON_RISE && ext_en && pin_rise) ||
                        (reload_sel == RELOAD_ON_FALL && ext_en && pin_fall) ||
                        (reload_sel == RELOAD_ON_EITHER && ext_en && pin_edge_any) ||
                        (reload_sel == RELOAD_ON_CAP0 && cap_rise) ||
                        (reload_sel == RELOAD_ON_CAP1 && cap_fall);
    wire overflow     = tick && count_q == COUNT_MAX;
    wire cap_evt      = ext_en && ((mode == MODE_CAPTURE_RISE && cap_rise) ||
                                   (mode == MODE_CAPTURE_FALL && cap_fall) ||
                                   (mode == MODE_CAPTURE_BOTH && (cap_rise || cap_fall)));
    wire [15:0] count_inc = count_q + 16'h0001;
    wire pwm_active   = run_bit && count_q < duty_q;

    always_comb
    begin
        count_d  = count_q;
        rcap_d   = wr_rcap ? hwdata[15:0] : rcap_q;
        tf_set   = 1'b0;
        exf_set  = 1'b0;
        baud_ovf = 1'b0;
        if (!run_bit)
        begin
            if (wr_cnt)
                count_d = hwdata[15:0];
        end
        else
        begin
            case (mode)
                MODE_AUTO_RELOAD:
                begin
                    if (overflow)
                    begin
                        tf_set  = 1'b1;
                        count_d = (reload_sel == RELOAD_ON_OVERFLOW) ? rcap_q : count_inc;
                    end
                    else if (tick)
                        count_d = count_inc;
                    if (reload_evt)
                    begin
                        count_d = rcap_q;
                        exf_set = 1'b1;
                    end
                end
                MODE_BAUD:
                begin
                    if (overflow)
                    begin
                        count_d  = rcap_q;
                        baud_ovf = 1'b1;
                    end
                    else if (tick)
                        count_d = count_inc;
                    exf_set = ext_en && pin_edge_any;
                end
                MODE_CAPTURE_RISE, MODE_CAPTURE_FALL, MODE_CAPTURE_BOTH:
                begin
                    if (tick)
                        count_d = count_inc;
                    tf_set = overflow;
                    if (cap_evt)
                    begin
                        rcap_d  = count_q;
                        exf_set = 1'b1;
                        if (cap_clear)
                            count_d = 16'h0000;
                    end
                end
                MODE_COMPARE:
                begin
                    if (tick)
                    begin
                        count_d = count_inc;
                        if (count_q == rcap_q)
                        begin
                            tf_set = 1'b1;
                            if (cmp_clear)
                                count_d = 16'h0000;
                        end
                    end
                end
                MODE_PWM:
                begin
                    if (tick)
                        count_d = (count_q >= period_q) ? 16'h0000 : count_inc;
                end
                default:
                    count_d = count_q;
            endcase
        end
    end

    // Bus and registers
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            addr_q       <= 8'h00;
            wr_q         <= 1'b0;
            hrdata_q     <= 32'h00000000;
            hreadyout_q  <= 1'b1;
            control_q    <= CONTROL_RESET;
            source_q     <= SOURCE_RESET[1:0];
            extended_q   <= EXTENDED_RESET;
            rcap_q       <= COUNT_RESET;
            period_q     <= COUNT_RESET;
            duty_q       <= COUNT_RESET;
            int_enable_q <= 1'b0;
        end
        else
        begin
            addr_q      <= raddr;
            wr_q        <= take && hwrite;
            hrdata_q    <= (take && !hwrite) ? rdata_mux : 32'h00000000;
            hreadyout_q <= 1'b1;
            rcap_q      <= rcap_d;
            if (wr_ctrl)
                control_q <= hwdata[7:0];
            if (wr_src)
                source_q <= hwdata[CAPTURE_SOURCE_LSB +: 2];
            if (wr_ext)
                extended_q <= hwdata[7:0];
            if (wr_per)
                period_q <= hwdata[15:0];
            if (wr_duty)
                duty_q <= hwdata[15:0];
            if (wr_ie)
                int_enable_q <= hwdata[INT_ENABLE_BIT];
        end
    end

    // Flags: a hardware set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            tf_q  <= 1'b0;
            exf_q <= 1'b0;
        end
        else
        begin
            tf_q  <= tf_set || (wr_ctrl ? hwdata[OVERFLOW_FLAG_BIT] : tf_q);
            exf_q <= exf_set || (wr_ctrl ? hwdata[EXT_EVENT_FLAG_BIT] : exf_q);
        end
    end

    // Counting engine
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            count_q     <= COUNT_RESET;
            pre_q       <= 8'h00;
            baud_div_q  <= '0;
            baud_tick_q <= 1'b0;
            irq_q       <= 1'b0;
            pwm_q       <= 1'b0;
            sync1_q     <= 4'h0;
            sync2_q     <= 4'h0;
            prev_q      <= 4'h0;
        end
        else
        begin
            count_q     <= count_d;
            pre_q       <= (!run_bit || tick) ? 8'h00 : pre_q + 8'h01;
            baud_div_q  <= baud_ovf ? baud_div_q + 1'b1 : baud_div_q;
            baud_tick_q <= baud_ovf && baud_div_q == '1;
            irq_q       <= int_enable_q && (tf_q || exf_q);
            pwm_q       <= pwm_active ^ polarity;
            sync1_q     <= {serial_two_receive_pin, serial_one_receive_pin, lf_rc_clk_pin, event_pin};
            sync2_q     <= sync1_q;
            prev_q      <= sync2_q;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign timer_irq = irq_q;
    assign baud_tick = baud_tick_q;
    assign pwm_out   = pwm_q;

    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_wrap;
        run_bit && mode == MODE_AUTO_RELOAD && reload_sel == RELOAD_ON_OVERFLOW && overflow && !reload_evt;
    endsequence

    chk_overflow_reload: assert property (s_wrap |=> count_q == $past(rcap_q) && tf_q)
        else $error("overflow did not reload and flag");
    chk_baud_quiet: assert property (mode == MODE_BAUD && overflow && !tf_q && !wr_ctrl |=> !tf_q)
        else $error("baud overflow raised the flag");
    chk_baud_event: assert property (mode == MODE_BAUD && run_bit && ext_en && pin_rise && !overflow
                                     |=> exf_q && count_q == $past(count_q) + 16'($past(tick)))
        else $error("baud pin edge reloaded or missed flag");
    chk_capture_copy: assert property (run_bit && cap_evt |=> rcap_q == $past(count_q) && exf_q)
        else $error("capture value or flag wrong");
    chk_compare_clear: assert property (run_bit && mode == MODE_COMPARE && tick && count_q == rcap_q && cmp_clear
                                        |=> count_q == 16'h0000 && tf_q)
        else $error("compare match not cleared");
    chk_stopped_hold: assert property (!run_bit && !wr_cnt |=> $stable(count_q))
        else $error("stopped counter moved");
    chk_flag_sticky: assert property (tf_q && !wr_ctrl |=> tf_q)
        else $error("overflow flag cleared by hardware");
    chk_irq_follow: assert property (int_enable_q && exf_q |=> timer_irq)
        else $error("interrupt not raised");
    // Match ends one cycle short of the next tick; seven quiet steps leave the divider at six
    chk_prescale_eight: assert property ((tick && prescale_sel == 2'h1 && !wr_ctrl)
                                         ##1 (!wr_ctrl)[*7] |-> pre_q == PRESCALE_END_8 - 8'h01 && !tick ##1 tick)
        else $error("divide by eight spacing wrong");

endmodule : timer5_reload_capture_compare

// file: pkg/timer5_pkg.sv
package timer5_pkg;

    // Register byte offsets
    localparam logic [7:0] CONTROL_OFFSET        = 8'h00;
    localparam logic [7:0] CAPTURE_SOURCE_OFFSET = 8'h04;
    localparam logic [7:0] EXTENDED_OFFSET       = 8'h08;
    localparam logic [7:0] COUNT_OFFSET          = 8'h0C;
    localparam logic [7:0] RELOAD_CAPTURE_OFFSET = 8'h10;
    localparam logic [7:0] PERIOD_OFFSET         = 8'h14;
    localparam logic [7:0] DUTY_OFFSET           = 8'h18;
    localparam logic [7:0] INT_ENABLE_OFFSET     = 8'h1C;

    // Control register fields
    localparam int OVERFLOW_FLAG_BIT   = 7;
    localparam int EXT_EVENT_FLAG_BIT  = 6;
    localparam int PRESCALE_LSB        = 4;
    localparam int MODE_LSB            = 2;
    localparam int RUN_BIT             = 1;
    localparam int EXT_TRIGGER_BIT     = 0;

    // Extended control fields
    localparam int PWM_POLARITY_BIT    = 7;
    localparam int RELOAD_SOURCE_LSB   = 4;
    localparam int EXTENDED_MODE_LSB   = 2;
    localparam int COMPARE_CLEAR_BIT   = 1;
    localparam int CAPTURE_CLEAR_BIT   = 0;

    // Capture source field and interrupt enable
    localparam int CAPTURE_SOURCE_LSB  = 0;
    localparam int INT_ENABLE_BIT      = 0;

    // Reset values
    localparam logic [7:0]  CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  SOURCE_RESET   = 8'h00;
    localparam logic [7:0]  EXTENDED_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;

    // Counter limits and prescaler terminal counts for 1, 8, 64, 256
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [7:0]  PRESCALE_END_1   = 8'h00;
    localparam logic [7:0]  PRESCALE_END_8   = 8'h07;
    localparam logic [7:0]  PRESCALE_END_64  = 8'h3F;
    localparam logic [7:0]  PRESCALE_END_256 = 8'hFF;

    // Reload trigger codes
    localparam logic [2:0] RELOAD_ON_OVERFLOW = 3'h0;
    localparam logic [2:0] RELOAD_ON_RISE     = 3'h1;
    localparam logic [2:0] RELOAD_ON_FALL     = 3'h2;
    localparam logic [2:0] RELOAD_ON_EITHER   = 3'h3;
    localparam logic [2:0] RELOAD_ON_CAP0     = 3'h4;
    localparam logic [2:0] RELOAD_ON_CAP1     = 3'h5;

    typedef enum logic [2:0] {
        MODE_AUTO_RELOAD,
        MODE_BAUD,
        MODE_CAPTURE_RISE,
        MODE_CAPTURE_FALL,
        MODE_CAPTURE_BOTH,
        MODE_COMPARE,
        MODE_PWM
    } mode_type;

endpackage : timer5_pkg

// file: verif/timer5_pin_model.sv
`timescale 1ns/1ps

module timer5_pin_model (
    // Clock
    input  wire logic ref_clk,
    // Pins toward the timer
    output logic      event_pin,
    output logic      lf_rc_clk_pin,
    output logic      serial_one_receive_pin,
    output logic      serial_two_receive_pin
);
    logic [3:0] level_q;

    // Receive lines idle high, as a quiet serial line does
    initial level_q = 4'hC;

    assign event_pin              = level_q[0];
    assign lf_rc_clk_pin          = level_q[1];
    assign serial_one_receive_pin = level_q[2];
    assign serial_two_receive_pin = level_q[3];

    // Each level is held four cycles; the two-flop sampler catches any level held one cycle
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge ref_clk);
        level_q[idx] <= lvl;
        repeat (4) @(posedge ref_clk);
    endtask : set_pin

    task automatic toggle_pin(input int idx);
        set_pin(idx, ~level_q[idx]);
    endtask : toggle_pin
endmodule : timer5_pin_model

// file: verif/timer5_reload_capture_compare_tb.sv
`timescale 1ns/1ps

module timer5_reload_capture_compare_tb;
    import timer5_pkg::*;

    logic        ref_clk, srst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rv, cnt, rl;
    logic [1:0]  htrans, md;
    logic        event_pin, lf_rc_clk_pin, serial_one_receive_pin, serial_two_receive_pin;
    logic        timer_irq, baud_tick, pwm_out;
    logic [31:0] model [bit [7:0]];
    int          n_errors = 0;
    int          tests_run = 0;
    int          k, hi;
    int          div [4] = '{1, 8, 64, 256};

    timer5_reload_capture_compare dut (
        .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .event_pin(event_pin), .lf_rc_clk_pin(lf_rc_clk_pin),
        .serial_one_receive_pin(serial_one_receive_pin), .serial_two_receive_pin(serial_two_receive_pin),
        .timer_irq(timer_irq), .baud_tick(baud_tick), .pwm_out(pwm_out)
    );

    timer5_pin_model pins (
        .ref_clk(ref_clk), .event_pin(event_pin), .lf_rc_clk_pin(lf_rc_clk_pin),
        .serial_one_receive_pin(serial_one_receive_pin), .serial_two_receive_pin(serial_two_receive_pin)
    );

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Readable width of each register except control; control and unmapped places give zero
    function automatic logic [31:0] reg_mask(input logic [7:0] a);
        case (a)
            CAPTURE_SOURCE_OFFSET: return 32'h3;
            EXTENDED_OFFSET:       return 32'hFF;
            INT_ENABLE_OFFSET:     return 32'h1;
            COUNT_OFFSET, RELOAD_CAPTURE_OFFSET, PERIOD_OFFSET, DUTY_OFFSET: return 32'hFFFF;
            default:               return 32'h0;
        endcase
    endfunction : reg_mask

    function automatic logic [31:0] ctl(input logic [1:0] ps, input logic [1:0] m, input logic run,
                                        input logic ext);
        return {24'h0, 2'b00, ps, m, run, ext};
    endfunction : ctl

    // Single AHB-Lite transfer; the address and data phases each wait for hready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(a, 1'b1, wd, d);
        model[a] = wd & reg_mask(a);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        xfer(a, 1'b0, 32'h0, d);
    endtask : rd

    task automatic rd_model(input logic [7:0] a);
        rd(a, rv);
        chk(rv, model[a]);
        chk(32'(hresp), 32'h0);
    endtask : rd_model

    task automatic wait_tick(output int n);
        n = 0;
        do begin @(posedge ref_clk); n++; end while (baud_tick !== 1'b1 && n < 5000);
    endtask : wait_tick

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run is about 10k cycles; ten times that means a hang
    initial
    begin
        #1_000_000;
        n_errors++;
        test_done();
    end

    initial
    begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        void'($urandom(32'h1caa52cc));
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (k = 0; k <= 32; k += 4)
        begin
            rd(k[7:0], rv);
            chk(rv, 32'h0);
        end
        wr(8'h20, 32'hFFFFFFFF);
        rd_model(8'h20);
        wr(CAPTURE_SOURCE_OFFSET, 32'hFFFFFFFF);
        rd_model(CAPTURE_SOURCE_OFFSET);
        wr(INT_ENABLE_OFFSET, 32'hFFFFFFFF);
        rd_model(INT_ENABLE_OFFSET);
        // Overflow with reload, interrupt level and software clear
        rl = 32'h4000 | ($urandom & 32'hFF);
        wr(RELOAD_CAPTURE_OFFSET, rl);
        wr(COUNT_OFFSET, 32'hFFF0);
        rd_model(COUNT_OFFSET);
        wr(CONTROL_OFFSET, ctl(2'd0, 2'd0, 1'b1, 1'b0));
        repeat (40) @(posedge ref_clk);
        rd(CONTROL_OFFSET, rv);
        chk(32'(rv[7:6]), 32'h2);
        chk(32'(timer_irq), 32'h1);
        wr(CONTROL_OFFSET, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(32'(timer_irq), 32'h0);
        rd(COUNT_OFFSET, cnt);
        chk(32'(cnt >= rl && cnt <= rl + 40), 32'h1);
        // Prescaler ratios, counting on from a preset value
        for (k = 0; k < 4; k++)
        begin
            rl = $urandom & 32'h0FFF;
            wr(COUNT_OFFSET, rl);
            wr(CONTROL_OFFSET, ctl(k[1:0], 2'd0, 1'b1, 1'b0));
            repeat (2048) @(posedge ref_clk);
            wr(CONTROL_OFFSET, 32'h0);
            rd(COUNT_OFFSET, cnt);
            hi = rl + 2048 / div[k];
            chk(32'(cnt + 3 >= hi && cnt <= hi + 4), 32'h1);
        end
        // Baud generator: tick spacing, no overflow flag, pin still flags
        rl = 32'hFFF0 | ($urandom & 32'h7);
        wr(RELOAD_CAPTURE_OFFSET, rl);
        wr(COUNT_OFFSET, rl);
        wr(CONTROL_OFFSET, ctl(2'd0, 2'd1, 1'b1, 1'b1));
        wait_tick(hi);
        wait_tick(hi);
        chk(hi, 16 * (65536 - rl));
        pins.toggle_pin(0);
        rd(CONTROL_OFFSET, rv);
        chk(32'(rv[7:6]), 32'h1);
        // Capture on every source and both edges, with and without auto-clear
        for (k = 0; k < 8; k++)
        begin
            md = (k < 4) ? 2'd2 : 2'd3;
            wr(CONTROL_OFFSET, 32'h0);
            // Source two runs in both-edge mode, once for each edge direction
            wr(EXTENDED_OFFSET, 32'(k % 2) | ((k % 4 == 2) ? 32'h4 : 32'h0));
            wr(CAPTURE_SOURCE_OFFSET, 32'(k % 4));
            pins.set_pin(k % 4, md == 2'd3);
            wr(COUNT_OFFSET, 32'h0);
            wr(CONTROL_OFFSET, ctl(2'd0, md, 1'b1, 1'b1));
            repeat (40) @(posedge ref_clk);
            pins.toggle_pin((k + 1) % 4);
            pins.toggle_pin((k + 1) % 4);
            rd(CONTROL_OFFSET, rv);
            chk(32'(rv[6]), 32'h0);
            pins.set_pin(k % 4, md == 2'd2);
            rd(CONTROL_OFFSET, rv);
            chk(32'(rv[7:6]), 32'h1);
            wr(CONTROL_OFFSET, 32'h0);
            rd(RELOAD_CAPTURE_OFFSET, rl);
            rd(COUNT_OFFSET, cnt);
            chk(32'(rl >= 40 && rl <= 90), 32'h1);
            chk(32'(cnt < rl), 32'(k % 2));
        end
        // Capture mode overflow runs on from zero without reload
        wr(EXTENDED_OFFSET, 32'h0);
        wr(RELOAD_CAPTURE_OFFSET, 32'h8000);
        wr(COUNT_OFFSET, 32'hFFF0);
        wr(CONTROL_OFFSET, ctl(2'd0, 2'd2, 1'b1, 1'b0));
        repeat (40) @(posedge ref_clk);
        rd(CONTROL_OFFSET, rv);
        chk(32'(rv[7]), 32'h1);
        wr(CONTROL_OFFSET, 32'h0);
        rd(COUNT_OFFSET, cnt);
        chk(32'(cnt <= 40), 32'h1);
        // Every reload source, each offered one rising edge on the event pin
        wr(CAPTURE_SOURCE_OFFSET, 32'h0);
        for (k = 0; k < 6; k++)
        begin
            wr(EXTENDED_OFFSET, 32'(k) << RELOAD_SOURCE_LSB);
            pins.set_pin(0, 1'b0);
            wr(COUNT_OFFSET, 32'h0100);
            wr(CONTROL_OFFSET, ctl(2'd0, 2'd0, 1'b1, 1'b1));
            pins.set_pin(0, 1'b1);
            rd(CONTROL_OFFSET, rv);
            if (k == 0)
                chk(32'({rv[6], timer_irq}), 32'h3);
            wr(CONTROL_OFFSET, 32'h0);
            rd(COUNT_OFFSET, cnt);
            chk(32'(cnt >= 32'h8000), 32'(k != 2 && k != 5));
        end
        // Compare match with and without clearing the count
        for (k = 0; k < 2; k++)
        begin
            wr(EXTENDED_OFFSET, 32'h8 | 32'(k << COMPARE_CLEAR_BIT));
            wr(RELOAD_CAPTURE_OFFSET, 32'h20);
            wr(COUNT_OFFSET, 32'h0);
            wr(CONTROL_OFFSET, ctl(2'd0, 2'd0, 1'b1, 1'b0));
            repeat (100) @(posedge ref_clk);
            rd(CONTROL_OFFSET, rv);
            chk(32'(rv[7]), 32'h1);
            wr(CONTROL_OFFSET, 32'h0);
            rd(COUNT_OFFSET, cnt);
            chk(32'(cnt <= 32'h20), 32'(k));
        end
        // PWM: period 9 gives ten steps, duty 4 of them active
        wr(PERIOD_OFFSET, 32'h9);
        wr(DUTY_OFFSET, 32'h4);
        for (k = 0; k < 2; k++)
        begin
            wr(COUNT_OFFSET, 32'h0);
            wr(EXTENDED_OFFSET, 32'hC | 32'(k << PWM_POLARITY_BIT));
            wr(CONTROL_OFFSET, ctl(2'd0, 2'd0, 1'b1, 1'b0));
            hi = 0;
            repeat (100) begin @(posedge ref_clk); hi += (pwm_out === 1'b1); end
            wr(CONTROL_OFFSET, 32'h0);
            chk(32'(hi >= 37 + 20 * k && hi <= 43 + 20 * k), 32'h1);
        end
        test_done();
    end
endmodule : timer5_reload_capture_compare_tb
